// file: fpexc_defs.svh
// fpexc_defs.svh: offsets, field positions, reset values and counts
// assumes inclusion by bare name from every file of the block that uses its macros
`ifndef FPEXC_DEFS_SVH
`define FPEXC_DEFS_SVH

// ****************************************
// widths
// ****************************************
`define FPEXC_N_EXC        5
`define FPEXC_TAG_W        8
`define FPEXC_CNT_W        8
`define FPEXC_ADR_W        8
`define FPEXC_N_IRQ        3

// ****************************************
// register byte offsets
// ****************************************
`define FPEXC_ADR_FP_STATUS_CONTROL_REG    8'h00
`define FPEXC_ADR_CTRL     8'h04
`define FPEXC_ADR_PEND     8'h08
`define FPEXC_ADR_IRQ_STAT 8'h0c
`define FPEXC_ADR_IRQ_MASK 8'h10

// ****************************************
// fields of fp_status_control_reg
// ****************************************
`define FPEXC_FLAG_LSB     0
`define FPEXC_EN_LSB       5
`define FPEXC_FEX_BIT      10
`define FPEXC_FX_BIT       11
// exception bits: 0 invalid, 1 overflow, 2 underflow, 3 zero divide, 4 inexact
`define FPEXC_SUPPRESS     5'h09

// ****************************************
// interrupt status bits
// ****************************************
`define FPEXC_IRQ_TAKEN    0
`define FPEXC_IRQ_RECORD   1
`define FPEXC_IRQ_FORCED   2

// ****************************************
// reset values and counts
// ****************************************
`define FPEXC_EN_RST       5'h00
`define FPEXC_MODE_RST     1'h0
`define FPEXC_MASK_RST     3'h0
`define FPEXC_DEFER_CYC    16

`endif

// file: fpexc_pkg.sv
// fpexc_pkg.sv: types of the fp enabled exception mode control
// assumes fpexc_defs.svh on the include path
`include "fpexc_defs.svh"

package fpexc_pkg;

   // {fp_exc_mode_bit0, fp_exc_mode_bit1}
   typedef enum logic [1:0] {
      FPEXC_IGNORE  = 2'b00,
      FPEXC_NONREC  = 2'b01,
      FPEXC_RECOV   = 2'b10,
      FPEXC_PRECISE = 2'b11
   } fpexc_mode_t;

   typedef enum logic [1:0] {
      FPEXC_IDLE = 2'b00,
      FPEXC_PEND = 2'b01,
      FPEXC_REQ  = 2'b10
   } fpexc_dstate_t;

   typedef struct packed {
      logic                        mode_bit0;
      logic                        mode_bit1;
      logic [`FPEXC_N_EXC-1:0]     en;
      fpexc_dstate_t               dstate;
      logic [`FPEXC_TAG_W-1:0]     tag;
      logic                        tag_valid;
      logic                        supp;
      logic                        track;
      logic [`FPEXC_CNT_W-1:0]     cnt;
      logic [`FPEXC_N_IRQ-1:0]     irq_mask;
      logic                        ack;
      logic [31:0]                 rdat;
   } fpexc_state_t;

endpackage : fpexc_pkg

// file: fpexc_flags.sv
// fpexc_flags.sv: bank of sticky flags, set wins over clear
// assumes set and clr come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none

module fpexc_flags #(
   parameter int W = 5
) (
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flags;
   } fpexc_flags_st_t;

   fpexc_flags_st_t st;
   fpexc_flags_st_t next_st;

   // ****************************************
   // per-bit update
   // ****************************************
   always_comb begin
      next_st = st;
      for (int i = 0; i < W; i++) begin
         // an event in the clearing cycle is kept
         next_st.flags[i] = set[i] | (st.flags[i] & ~clr[i]);
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flags;

endmodule : fpexc_flags

`default_nettype wire

// file: fpexc_ctrl.sv
// fpexc_ctrl.sv: fp enabled exception mode control with wishbone registers
// assumes completion logic reports each completing instruction for one cycle,
// and exception entry logic answers a request with exc_ack
//
// Summary of operation
// - ignore mode never requests the handler
// - disabled conditions never request the handler
// - enabled condition requests handler in other modes
// - nonrecoverable mode delivers late, tag kept but not marked valid
// - nonrecoverable mode does not hold younger instructions
// - recoverable mode delivers late with offending tag
// - recoverable mode holds younger until handler entry
// - precise mode requests at offending instruction
// - precise mode blocks all younger instructions
// - entry instruction unexecuted unless unsuppressed offender
// - status register instruction forces pending delivery
// - no forcing effect in ignore mode
// - synchronizing event also forces pending delivery
// - flags always recorded, even in ignore mode
// - summary flag set for enabled set condition
// - set summary after completion raises exception
`timescale 1ns/10ps
`default_nettype none
`include "fpexc_defs.svh"

module fpexc_ctrl #(
   parameter int DEFER_CYCLES = `FPEXC_DEFER_CYC
) (
   input  wire logic                    clock,
   input  wire logic                    reset,
   // wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [`FPEXC_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // completion side
   input  wire logic                    cmp_valid,
   input  wire logic [`FPEXC_N_EXC-1:0] cmp_exc,
   input  wire logic [`FPEXC_TAG_W-1:0] cmp_tag,
   input  wire logic                    cmp_is_fp_status_control_reg_op,
   input  wire logic                    sync_event,
   // exception entry side
   output logic                         exc_req,
   output logic [`FPEXC_TAG_W-1:0]      exc_tag,
   output logic                         exc_tag_valid,
   output logic                         exc_suppress,
   input  wire logic                    exc_ack,
   output logic                         hold_younger,
   output logic                         irq
);

   // ****************************************
   // state
   // ****************************************
   fpexc_pkg::fpexc_state_t st;
   fpexc_pkg::fpexc_state_t next_st;

   localparam logic [`FPEXC_CNT_W-1:0] DEFER_LOAD =
      (DEFER_CYCLES > 1) ? `FPEXC_CNT_W'(DEFER_CYCLES - 1) : '0;

   logic [`FPEXC_N_EXC:0]     flag_set;
   logic [`FPEXC_N_EXC:0]     flag_clr;
   logic [`FPEXC_N_EXC:0]     flag_q;
   logic [`FPEXC_N_IRQ-1:0]   irq_set;
   logic [`FPEXC_N_IRQ-1:0]   irq_clr;
   logic [`FPEXC_N_IRQ-1:0]   irq_stat;
   logic [`FPEXC_N_EXC-1:0]   exc_bits;
   logic                      fx;
   logic                      fp_enabled_exc_summary;
   logic                      fex_after;
   fpexc_pkg::fpexc_mode_t    mode;
   logic                      mode_on;
   logic                      trig;
   logic                      force_req;
   logic                      bus_req;
   logic                      bus_wr;
   logic                      taken;
   logic                      forced;

   assign exc_bits = flag_q[`FPEXC_N_EXC-1:0];
   assign fx       = flag_q[`FPEXC_N_EXC];
   assign mode     = fpexc_pkg::fpexc_mode_t'({st.mode_bit0, st.mode_bit1});
   assign mode_on  = (mode != fpexc_pkg::FPEXC_IGNORE);
   assign bus_req  = wb_cyc_i & wb_stb_i & ~st.ack;
   assign bus_wr   = bus_req & wb_we_i;

   // ****************************************
   // status flags
   // ****************************************
   // conditions recorded whatever the mode
   assign flag_set = {cmp_valid & |(cmp_exc & ~exc_bits),
                      cmp_valid ? cmp_exc : {`FPEXC_N_EXC{1'b0}}};
   assign flag_clr = (bus_wr && wb_adr_i == `FPEXC_ADR_FP_STATUS_CONTROL_REG && wb_sel_i[1])
                   ? {wb_dat_i[`FPEXC_FX_BIT], wb_dat_i[`FPEXC_N_EXC-1:0]}
                   : '0;

   fpexc_flags #(
      .W (`FPEXC_N_EXC + 1)
   ) u_fp_status_control_reg_flags (
      .clock (clock),
      .reset (reset),
      .set   (flag_set),
      .clr   (flag_clr),
      .flags (flag_q)
   );

   assign fp_enabled_exc_summary       = |(exc_bits & st.en);
   assign fex_after = |((exc_bits | cmp_exc) & st.en);

   // summary still set after completion raises the exception
   assign trig = cmp_valid & fex_after & mode_on;

   // forcing only counts in the imprecise modes
   assign force_req = (cmp_valid & cmp_is_fp_status_control_reg_op) | sync_event;

   // ****************************************
   // interrupt flags
   // ****************************************
   assign taken   = (st.dstate == fpexc_pkg::FPEXC_REQ) & exc_ack & mode_on;
   assign forced  = (st.dstate == fpexc_pkg::FPEXC_PEND) & force_req & mode_on;
   assign irq_set = {forced, cmp_valid & |cmp_exc, taken};
   assign irq_clr = (bus_wr && wb_adr_i == `FPEXC_ADR_IRQ_STAT && wb_sel_i[0])
                  ? wb_dat_i[`FPEXC_N_IRQ-1:0]
                  : '0;

   fpexc_flags #(
      .W (`FPEXC_N_IRQ)
   ) u_irq_flags (
      .clock (clock),
      .reset (reset),
      .set   (irq_set),
      .clr   (irq_clr),
      .flags (irq_stat)
   );

   assign irq = |(irq_stat & st.irq_mask);

   // ****************************************
   // delivery and register file
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.ack = bus_req;

      // -------- delivery --------
      case (st.dstate)
         fpexc_pkg::FPEXC_IDLE: begin
            if (trig) begin
               next_st.supp = |(cmp_exc & st.en & `FPEXC_SUPPRESS);
               next_st.tag  = cmp_tag;
               // nonrecoverable stores the offender tag but marks it invalid, so exc_tag reads zero
               next_st.tag_valid = (mode != fpexc_pkg::FPEXC_NONREC);
               next_st.track = (mode == fpexc_pkg::FPEXC_RECOV) ||
                               (mode == fpexc_pkg::FPEXC_PRECISE);
               if (mode == fpexc_pkg::FPEXC_PRECISE) begin
                  next_st.dstate = fpexc_pkg::FPEXC_REQ;
               end else if (force_req) begin
                  next_st.dstate = fpexc_pkg::FPEXC_REQ;
               end else begin
                  next_st.dstate = fpexc_pkg::FPEXC_PEND;
                  next_st.cnt    = DEFER_LOAD;
               end
            end
         end
         fpexc_pkg::FPEXC_PEND: begin
            if (!mode_on) begin
               next_st.dstate = fpexc_pkg::FPEXC_IDLE;
            end else if (force_req || st.cnt == '0) begin
               next_st.dstate = fpexc_pkg::FPEXC_REQ;
            end else begin
               // held until forced or the deferral runs out
               next_st.cnt = st.cnt - `FPEXC_CNT_W'(1);
            end
         end
         fpexc_pkg::FPEXC_REQ: begin
            if (!mode_on || exc_ack) begin
               next_st.dstate = fpexc_pkg::FPEXC_IDLE;
               next_st.track  = 1'b0;
            end
         end
         default: begin
            next_st.dstate = fpexc_pkg::FPEXC_IDLE;
         end
      endcase

      // -------- register writes --------
      if (bus_wr && wb_adr_i == `FPEXC_ADR_FP_STATUS_CONTROL_REG) begin
         if (wb_sel_i[0]) begin
            next_st.en[2:0] = wb_dat_i[`FPEXC_EN_LSB+2:`FPEXC_EN_LSB];
         end
         if (wb_sel_i[1]) begin
            next_st.en[4:3] = wb_dat_i[`FPEXC_EN_LSB+4:`FPEXC_EN_LSB+3];
         end
      end else if (bus_wr && wb_adr_i == `FPEXC_ADR_CTRL) begin
         if (wb_sel_i[0]) begin
            next_st.mode_bit0 = wb_dat_i[0];
            next_st.mode_bit1 = wb_dat_i[1];
         end
      end else if (bus_wr && wb_adr_i == `FPEXC_ADR_IRQ_MASK) begin
         if (wb_sel_i[0]) begin
            next_st.irq_mask = wb_dat_i[`FPEXC_N_IRQ-1:0];
         end
      end

      // -------- register reads --------
      next_st.rdat = 32'h0;
      if (bus_req && !wb_we_i) begin
         if (wb_adr_i == `FPEXC_ADR_FP_STATUS_CONTROL_REG) begin
            next_st.rdat[`FPEXC_N_EXC-1:0] = exc_bits;
            next_st.rdat[`FPEXC_EN_LSB+4:`FPEXC_EN_LSB] = st.en;
            next_st.rdat[`FPEXC_FEX_BIT] = fp_enabled_exc_summary;
            next_st.rdat[`FPEXC_FX_BIT]  = fx;
         end else if (wb_adr_i == `FPEXC_ADR_CTRL) begin
            next_st.rdat[1:0] = {st.mode_bit1, st.mode_bit0};
         end else if (wb_adr_i == `FPEXC_ADR_PEND) begin
            next_st.rdat[1:0] = st.dstate;
            next_st.rdat[2]   = st.tag_valid;
            next_st.rdat[3]   = st.supp;
            next_st.rdat[15:8] = st.tag;
         end else if (wb_adr_i == `FPEXC_ADR_IRQ_STAT) begin
            next_st.rdat[`FPEXC_N_IRQ-1:0] = irq_stat;
         end else if (wb_adr_i == `FPEXC_ADR_IRQ_MASK) begin
            next_st.rdat[`FPEXC_N_IRQ-1:0] = st.irq_mask;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         st           <= '0;
         st.mode_bit0 <= `FPEXC_MODE_RST;
         st.mode_bit1 <= `FPEXC_MODE_RST;
         st.en        <= `FPEXC_EN_RST;
         st.irq_mask  <= `FPEXC_MASK_RST;
         st.dstate    <= fpexc_pkg::FPEXC_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   // gated by mode so a switch to ignore drops the request at once
   assign exc_req       = (st.dstate == fpexc_pkg::FPEXC_REQ) & mode_on;
   assign exc_tag       = st.tag_valid ? st.tag : '0;
   assign exc_tag_valid = st.tag_valid;
   assign exc_suppress  = st.supp;
   // younger work stalls from the offending completion until entry;
   // costs throughput, the price of recoverable and precise modes
   assign hold_younger  = (trig & ((mode == fpexc_pkg::FPEXC_RECOV) ||
                                   (mode == fpexc_pkg::FPEXC_PRECISE))) |
                          ((st.dstate != fpexc_pkg::FPEXC_IDLE) & st.track);
   assign wb_ack_o      = st.ack;
   assign wb_dat_o      = st.rdat;

endmodule : fpexc_ctrl

`default_nettype wire

// file: fpexc_ctrl_checker.sv
// fpexc_ctrl_checker.sv: port assertions of fpexc_ctrl
// assumes a bind from the bench, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "fpexc_defs.svh"
module fpexc_ctrl_checker (
   input wire logic                   clock,
   input wire logic                   reset,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_we_i,
   input wire logic [31:0]            wb_dat_o,
   input wire logic                   wb_ack_o,
   input wire logic                   cmp_valid,
   input wire logic                   exc_req,
   input wire logic [`FPEXC_TAG_W-1:0] exc_tag,
   input wire logic                   exc_tag_valid,
   input wire logic                   exc_ack,
   input wire logic                   hold_younger
);
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence bus_taken;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // a mode write may drop the request at once, so writes are left out
   sequence req_waits;
      exc_req && !exc_ack && !wb_we_i;
   endsequence
   sequence entry_done;
      exc_req && exc_ack ##1 !cmp_valid;
   endsequence
   bus_answer_a: assert property (bus_taken |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer late or long");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   req_holds_a: assert property (req_waits |=> exc_req)
      else $error("request dropped before ack");
   req_drops_a: assert property (exc_req && exc_ack |=> !exc_req)
      else $error("request stays after ack");
   tag_kept_a: assert property (req_waits |=> $stable(exc_tag) && $stable(exc_tag_valid))
      else $error("offending tag changed");
   tag_blank_a: assert property (!exc_tag_valid |-> exc_tag == 8'h00)
      else $error("tag without valid");
   younger_held_a: assert property (exc_req && exc_tag_valid |-> hold_younger)
      else $error("younger not held");
   hold_free_a: assert property (entry_done |-> !hold_younger)
      else $error("hold stays after entry");
endmodule : fpexc_ctrl_checker
`default_nettype wire

// file: fpexc_entry_model.sv
// fpexc_entry_model.sv: exception entry logic taking handler requests
// assumes exc_req is a level held until exc_ack
`timescale 1ns/10ps
`default_nettype none
module fpexc_entry_model (
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic exc_req,
   input  wire logic slow,
   output logic      exc_ack
);
   logic [2:0] wait_cnt;
   // ack only against a standing request; slow stalls entry five cycles
   always_ff @(posedge clock) begin
      if (reset || exc_ack || !exc_req) begin
         exc_ack <= 1'b0;
         wait_cnt <= 3'h0;
      end else if (slow && wait_cnt != 3'h5) begin
         wait_cnt <= wait_cnt + 3'h1;
      end else begin
         exc_ack <= 1'b1;
      end
   end
endmodule : fpexc_entry_model
`default_nettype wire

// file: fpexc_ctrl_test.sv
// fpexc_ctrl_test.sv: self-checking bench of fpexc_ctrl
// assumes checker and entry model compiled first
`timescale 1ns/10ps
`default_nettype none
`include "fpexc_defs.svh"
module fpexc_ctrl_test;
   logic        clock, reset, cyc, stb, we, cv, fp, sy, slow, req_q;
   logic        ack, req, tv, sup, xack, hold, irq;
   logic [7:0]  adr, tg, t, xtag;
   logic [3:0]  sel;
   logic [4:0]  ex;
   logic [31:0] di, dat;
   logic [31:0] rd_q[$];
   logic [7:0]  tag_q[$];
   int          error_cnt, check_count, seed, i;
   fpexc_ctrl #(.DEFER_CYCLES(6)) fpexc_ctrl_inst (.clock(clock), .reset(reset),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(di), .wb_dat_o(dat), .wb_ack_o(ack), .cmp_valid(cv), .cmp_exc(ex),
      .cmp_tag(tg), .cmp_is_fp_status_control_reg_op(fp), .sync_event(sy), .exc_req(req),
      .exc_tag(xtag), .exc_tag_valid(tv), .exc_suppress(sup), .exc_ack(xack),
      .hold_younger(hold), .irq(irq));
   fpexc_entry_model fpexc_entry_model_inst (.clock(clock), .reset(reset),
      .exc_req(req), .slow(slow), .exc_ack(xack));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         error_cnt++;
      end
   endtask : chk
   task automatic end_sim;
      if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic timeout;
      error_cnt++;
      end_sim;
   endtask : timeout
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      di <= d;
      sel <= s;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n >= 20) timeout();
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rd_q.push_back(e);
      wb(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   // one completing instruction; hold seen in its cycle, request one later
   task automatic cmp(input logic [4:0] e, input logic f, input logic [7:0] tag,
                      input logic h, input logic r);
      @(posedge clock);
      cv <= 1'b1;
      ex <= e;
      fp <= f;
      tg <= tag;
      #1 chk(hold, h);
      @(posedge clock);
      cv <= 1'b0;
      #1 chk(req, r);
   endtask : cmp
   // waits for entry, then clears flags and summary, sets all enables
   task automatic drain;
      int n;
      for (n = 0; n < 30 && req !== 1'b0; n++) @(posedge clock);
      if (n >= 30) timeout();
      wb(1'b1, `FPEXC_ADR_FP_STATUS_CONTROL_REG, 32'hbff, 4'h3);
   endtask : drain
   // unexpected handler entries pop an empty queue and mismatch
   always @(posedge clock) begin
      if (ack === 1'b1 && we === 1'b0) chk(dat, rd_q.pop_front());
      if (req === 1'b1 && req_q !== 1'b1) chk(xtag, tag_q.pop_front());
      req_q <= req;
   end
   initial begin
      repeat (40000) @(posedge clock);
      timeout();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      seed = 71;
      {cyc, stb, we, cv, fp, sy, slow} = '0;
      {adr, tg, t, sel, ex, di} = '0;
      reset = 1'b1;
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      for (i = 0; i <= 20; i += 4) rd(8'(i), 32'h0);
      wb(1'b1, `FPEXC_ADR_FP_STATUS_CONTROL_REG, 32'h3e0, 4'h3);
      wb(1'b1, `FPEXC_ADR_IRQ_MASK, 32'h7, 4'h1);
      cmp(5'h01, 1'b0, 8'h11, 1'b0, 1'b0);
      cmp(5'h00, 1'b1, 8'h12, 1'b0, 1'b0);
      rd(`FPEXC_ADR_FP_STATUS_CONTROL_REG, 32'hfe1);
      chk(irq, 1'b1);
      wb(1'b1, `FPEXC_ADR_IRQ_STAT, 32'h7, 4'h1);
      #1 chk(irq, 1'b0);
      wb(1'b1, `FPEXC_ADR_FP_STATUS_CONTROL_REG, 32'hbff, 4'h3);
      wb(1'b1, `FPEXC_ADR_CTRL, 32'h3, 4'h1);
      wb(1'b1, `FPEXC_ADR_FP_STATUS_CONTROL_REG, 32'hbdf, 4'h3);
      cmp(5'h01, 1'b0, 8'h13, 1'b0, 1'b0);
      drain;
      for (i = 0; i < 5; i++) begin
         slow <= i[0];
         t = 8'($random(seed));
         tag_q.push_back(t);
         // stale status would make the irq check below pass on its own
         wb(1'b1, `FPEXC_ADR_IRQ_STAT, 32'h7, 4'h1);
         cmp(5'(1 << i), 1'b0, t, 1'b1, 1'b1);
         chk(sup, 32'((`FPEXC_SUPPRESS >> i) & 5'h1));
         chk(tv, 1'b1);
         chk(irq, 1'b1);
         drain;
      end
      wb(1'b1, `FPEXC_ADR_IRQ_MASK, 32'h0, 4'h1);
      #1 chk(irq, 1'b0);
      wb(1'b1, `FPEXC_ADR_IRQ_STAT, 32'h7, 4'h1);
      wb(1'b1, `FPEXC_ADR_IRQ_MASK, 32'h7, 4'h1);
      #1 chk(irq, 1'b0);
      wb(1'b1, `FPEXC_ADR_CTRL, 32'h1, 4'h1);
      t = 8'($random(seed));
      tag_q.push_back(t);
      cmp(5'h10, 1'b0, t, 1'b1, 1'b0);
      cmp(5'h00, 1'b1, 8'h00, 1'b1, 1'b1);
      chk(tv, 1'b1);
      drain;
      rd(`FPEXC_ADR_IRQ_STAT, 32'h7);
      wb(1'b1, `FPEXC_ADR_CTRL, 32'h2, 4'h1);
      rd(`FPEXC_ADR_CTRL, 32'h2);
      tag_q.push_back(8'h00);
      cmp(5'h04, 1'b0, 8'h5a, 1'b0, 1'b0);
      @(posedge clock);
      sy <= 1'b1;
      @(posedge clock);
      sy <= 1'b0;
      #1 chk(req, 1'b1);
      chk(tv, 1'b0);
      drain;
      wb(1'b1, `FPEXC_ADR_CTRL, 32'h1, 4'h1);
      t = 8'($random(seed));
      tag_q.push_back(t);
      cmp(5'h02, 1'b0, t, 1'b1, 1'b0);
      for (i = 0; i < 12 && req !== 1'b1; i++) @(posedge clock);
      chk(req, 1'b1);
      // six pending cycles, then one more edge before the loop sees it
      chk(32'(i), 32'h7);
      drain;
      rd(`FPEXC_ADR_PEND, {16'h0, t, 8'h04});
      chk(tag_q.size(), 32'h0);
      end_sim;
   end
endmodule : fpexc_ctrl_test
bind fpexc_ctrl fpexc_ctrl_checker fpexc_ctrl_checker_inst (.clock(clock), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .cmp_valid(cmp_valid), .exc_req(exc_req), .exc_tag(exc_tag),
   .exc_tag_valid(exc_tag_valid), .exc_ack(exc_ack), .hold_younger(hold_younger));
`default_nettype wire
